/* core/mtb_params.svh */
// microcode test and branch control constants
// assumes an 8-bit low-byte field and a 2-bit mode field from the pipeline register
`ifndef MTB_PARAMS_SVH
`define MTB_PARAMS_SVH
`define MTB_MODE_TEST_BRANCH 2'h0
`define MTB_MODE_TEST_PCP 2'h1
`define MTB_BIT_TEST_TYPE 5
`define MTB_BIT_POLARITY 4
`define MTB_TSEL_HI 3
`define MTB_FIELD_HI 7
`define MTB_BTYPE_LO 6
`define MTB_PCP_LO 5
`define MTB_CNT_ALL_ONES 8'hff
`define MTB_CNT_ZERO 8'h00
`define MTB_SNAP_RESET 8'h00
`endif

/* core/mtb_pkg.sv */
// types for the microcode test and branch control block
// assumes mtb_params.svh is not needed here
package mtb_pkg;
   typedef enum logic [1:0] {
      MTB_BR_REPLACE = 2'h0,
      MTB_BR_IMSKIP = 2'h1,
      MTB_BR_REPEAT = 2'h2,
      MTB_BR_CONT_OVERRIDE = 2'h3
   } mtb_branch_e;
   typedef enum logic [2:0] {
      MTB_PCP_CARRY_OR = 3'h0,
      MTB_PCP_LOOP_COUNT_CLEAR = 3'h1,
      MTB_PCP_LOOP_COUNT_INCREMENT = 3'h2,
      MTB_PCP_LOOP_COUNT_DECREMENT = 3'h3,
      MTB_PCP_SNAPSHOT_LOAD = 3'h4,
      MTB_PCP_TOGGLE_COUNTER_ENABLE = 3'h5,
      MTB_PCP_CONTROL_POINT_UNUSED = 3'h6,
      MTB_PCP_NONE = 3'h7
   } mtb_pcp_e;
   typedef enum logic [1:0] {
      MTB_CE_STOPPED = 2'b01,
      MTB_CE_RUNNING = 2'b10
   } mtb_ce_e;
endpackage : mtb_pkg

/* core/mtb_control.sv */
// microcode test, implicit-branch and processor control point decoder
// assumes pipeline fields and flags come from logic on i_clock
//
// Functional notes
// - drop-through true sets continue override flipflop
// - test type 0 uses main mux, bits 0-3
// - test type 1 uses preloaded alternate select
// - bit 4 polarity: 0 false branches, 1 true
// - codes 000-011: carry or, loop clear/inc/dec
// - 100 snapshot, 101 toggle, 110 spare, 111 none
// - snapshot captured next edge, readable by ALU
// - snapshot bit order carry..result msb
// - nonzero means not zero, or not ones upward
// - loading either ram counter sets count enable
// - toggle alternately stops and restarts counters
// - stop reaches o_counter_enable next clock; only ce_gate drops in toggling instruction
// - restart counts from next clock after
// - repeat exit polarity given by bit 4
// - branch type bits 7..6 encode four modes
// - implicit branch only in mode 0, force continue
// - control points only in mode 1, force continue
`timescale 1ns/1ps
`include "mtb_params.svh"
module mtb_control #(
   parameter int COUNT_W = 8
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_valid,
   input wire logic [1:0] i_mode,
   input wire logic [7:0] i_field,
   input wire logic [15:0] i_main_tests,
   input wire logic [7:0] i_alt_tests,
   input wire logic i_alt_sel_load,
   input wire logic [2:0] i_alt_sel_data,
   input wire logic i_carry_in,
   input wire logic i_carry_delayed,
   input wire logic i_carry_out,
   input wire logic i_alu_zero,
   input wire logic i_own_flag_one,
   input wire logic i_peer_flag_three,
   input wire logic i_mid_carry,
   input wire logic i_arith_overflow,
   input wire logic i_result_msb,
   input wire logic i_host_counter_load,
   input wire logic i_inner_counter_load,
   output logic o_force_continue,
   output logic o_branch_take,
   output logic [1:0] o_branch_type,
   output logic o_repeat_exit,
   output logic o_carry_in,
   output logic [COUNT_W-1:0] o_loop_count,
   output logic o_loop_count_up,
   output logic o_loop_count_nonzero,
   output logic [7:0] o_flag_snapshot,
   output logic o_counter_enable,
   output logic o_continue_override
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic is_mode(input logic [1:0] m, input logic [1:0] want);
      is_mode = (m == want);
   endfunction : is_mode

   logic [COUNT_W-1:0] loop_count_q, loop_count_d;
   logic loop_up_q, loop_up_d;
   logic [2:0] alt_sel_q;
   logic [7:0] snap_q, snap_d;
   logic over_q, over_d;
   logic force_q, take_q, rexit_q, cin_q, nz_q;
   logic [1:0] btype_q;
   mtb_pkg::mtb_ce_e ce_q, ce_d;

   wire branch_mode = i_valid && is_mode(i_mode, `MTB_MODE_TEST_BRANCH);
   wire pcp_mode = i_valid && is_mode(i_mode, `MTB_MODE_TEST_PCP);
   wire conditional_sequencing = i_valid && !branch_mode && !pcp_mode;
   wire test_type = i_field[`MTB_BIT_TEST_TYPE];
   wire polarity = i_field[`MTB_BIT_POLARITY];
   wire main_test = i_main_tests[i_field[`MTB_TSEL_HI:0]];
   wire alt_test = i_alt_tests[alt_sel_q];
   wire test_val = test_type ? alt_test : main_test;
   wire test_hit = (test_val == polarity);
   // control point mode has no test type bit: bit 5 belongs to the code
   wire main_hit = (main_test == polarity);
   wire [1:0] btype = i_field[`MTB_FIELD_HI:`MTB_BTYPE_LO];
   wire [2:0] processor_control_point = i_field[`MTB_FIELD_HI:`MTB_PCP_LO];
   wire do_pcp = pcp_mode;
   wire is_clr = do_pcp && processor_control_point == mtb_pkg::MTB_PCP_LOOP_COUNT_CLEAR;
   wire is_inc = do_pcp && processor_control_point == mtb_pkg::MTB_PCP_LOOP_COUNT_INCREMENT;
   wire is_dec = do_pcp && processor_control_point == mtb_pkg::MTB_PCP_LOOP_COUNT_DECREMENT;
   wire is_cor = do_pcp && processor_control_point == mtb_pkg::MTB_PCP_CARRY_OR;
   wire is_snap = do_pcp && processor_control_point == mtb_pkg::MTB_PCP_SNAPSHOT_LOAD;
   wire is_tog = do_pcp && processor_control_point == mtb_pkg::MTB_PCP_TOGGLE_COUNTER_ENABLE;
   wire cnt_load = i_host_counter_load || i_inner_counter_load;
   wire set_over = branch_mode && btype == mtb_pkg::MTB_BR_CONT_OVERRIDE && test_hit;
   wire use_over = conditional_sequencing && over_q;
   wire nz_now = loop_up_q ? (loop_count_q != `MTB_CNT_ALL_ONES) : (loop_count_q != `MTB_CNT_ZERO);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      over_d = over_q;
      if (use_over) begin
         over_d = 1'b0;
      end
      if (set_over) begin
         over_d = 1'b1;
      end
      loop_count_d = loop_count_q;
      loop_up_d = loop_up_q;
      if (is_clr) begin
         loop_count_d = '0;
      end else if (is_inc) begin
         loop_count_d = loop_count_q + 1'b1;
         loop_up_d = 1'b1;
      end else if (is_dec) begin
         loop_count_d = loop_count_q - 1'b1;
         loop_up_d = 1'b0;
      end
      snap_d = is_snap ? {i_result_msb, i_arith_overflow, nz_now, i_mid_carry,
                          i_peer_flag_three, i_own_flag_one, i_alu_zero, i_carry_out} : snap_q;
      ce_d = ce_q;
      if (cnt_load) begin
         ce_d = mtb_pkg::MTB_CE_RUNNING;
      end else if (is_tog) begin
         case (ce_q)
            mtb_pkg::MTB_CE_RUNNING: ce_d = mtb_pkg::MTB_CE_STOPPED;
            mtb_pkg::MTB_CE_STOPPED: ce_d = mtb_pkg::MTB_CE_RUNNING;
            default: ce_d = mtb_pkg::MTB_CE_STOPPED;
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         over_q <= 1'b0;
         ce_q <= mtb_pkg::MTB_CE_STOPPED;
         loop_count_q <= '0;
         loop_up_q <= 1'b0;
         alt_sel_q <= 3'h0;
         snap_q <= `MTB_SNAP_RESET;
      end else begin
         over_q <= over_d;
         ce_q <= ce_d;
         loop_count_q <= loop_count_d;
         loop_up_q <= loop_up_d;
         snap_q <= snap_d;
         if (i_alt_sel_load) begin
            alt_sel_q <= i_alt_sel_data;
         end
      end
   end

   // output stage: each output is registered one cycle after its cause
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         force_q <= 1'b0;
         take_q <= 1'b0;
         btype_q <= 2'h0;
         rexit_q <= 1'b0;
         cin_q <= 1'b0;
         nz_q <= 1'b0;
      end else begin
         force_q <= branch_mode || pcp_mode || use_over;
         take_q <= branch_mode && test_hit;
         btype_q <= btype;
         rexit_q <= branch_mode ? test_hit : (pcp_mode && main_hit);
         cin_q <= is_cor ? (i_carry_in | i_carry_delayed) : i_carry_in;
         nz_q <= (loop_up_d ? (loop_count_d != `MTB_CNT_ALL_ONES) : (loop_count_d != `MTB_CNT_ZERO));
      end
   end

   // stop is immediate (from this cycle's decode), restart only after
   wire ce_gate = (ce_q == mtb_pkg::MTB_CE_RUNNING) && !(is_tog && !cnt_load);
   logic ce_out_q;
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ce_out_q <= 1'b0;
      end else begin
         ce_out_q <= (ce_d == mtb_pkg::MTB_CE_RUNNING);
      end
   end

   assign o_force_continue = force_q;
   assign o_branch_take = take_q;
   assign o_branch_type = btype_q;
   assign o_repeat_exit = rexit_q;
   assign o_carry_in = cin_q;
   assign o_loop_count = loop_count_q;
   assign o_loop_count_up = loop_up_q;
   assign o_loop_count_nonzero = nz_q;
   assign o_flag_snapshot = snap_q;
   assign o_counter_enable = ce_out_q;
   assign o_continue_override = over_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);

   sequence s_snap_cmd;
      is_snap;
   endsequence
   chk_override_set: assert property (set_over |=> over_q) else $error("override not set");
   chk_override_clear: assert property (use_over && !set_over |=> !over_q) else $error("override stuck");
   chk_override_force: assert property (use_over |=> o_force_continue) else $error("no forced continue");
   chk_branch_mode: assert property (branch_mode |=> o_force_continue) else $error("mode 0 no continue");
   chk_pcp_mode: assert property (pcp_mode |=> o_force_continue) else $error("mode 1 no continue");
   chk_take_polarity: assert property (branch_mode && !test_type |=>
      o_branch_take == ($past(main_test) == $past(polarity))) else $error("bad polarity");
   chk_snap_load: assert property (s_snap_cmd |=> o_flag_snapshot[0] == $past(i_carry_out)
      && o_flag_snapshot[7] == $past(i_result_msb)) else $error("snapshot wrong");
   chk_clear_count: assert property (is_clr |=> o_loop_count == '0) else $error("count not cleared");
   chk_load_enable: assert property (cnt_load |=> o_counter_enable) else $error("load no enable");
   chk_toggle_stop: assert property (is_tog && !cnt_load && ce_q == mtb_pkg::MTB_CE_RUNNING
      |-> !ce_gate ##1 !o_counter_enable) else $error("stop late");
   chk_toggle_start: assert property (is_tog && !cnt_load && ce_q == mtb_pkg::MTB_CE_STOPPED
      |=> o_counter_enable) else $error("restart missing");

   // ----------------------------------------
   // loop counter checks
   // ----------------------------------------
   sequence s_inc_cmd;
      is_inc;
   endsequence

   sequence s_dec_cmd;
      is_dec;
   endsequence

   chk_count_increment: assert property (s_inc_cmd |=>
      o_loop_count == $past(loop_count_q) + 1'b1 && o_loop_count_up)
      else $error("increment wrong");
   chk_count_decrement: assert property (s_dec_cmd |=>
      o_loop_count == $past(loop_count_q) - 1'b1 && !o_loop_count_up)
      else $error("decrement wrong");
   chk_count_hold: assert property (!is_clr && !is_inc && !is_dec |=>
      $stable(o_loop_count) && $stable(o_loop_count_up))
      else $error("count moved");
   chk_nonzero_flag: assert property (o_loop_count_nonzero ==
      (o_loop_count_up ? (o_loop_count != `MTB_CNT_ALL_ONES) : (o_loop_count != `MTB_CNT_ZERO)))
      else $error("nonzero flag wrong");

   // ----------------------------------------
   // carry and snapshot checks
   // ----------------------------------------
   chk_carry_or: assert property (is_cor |=>
      o_carry_in == ($past(i_carry_in) | $past(i_carry_delayed)))
      else $error("carry or wrong");
   chk_carry_pass: assert property (!is_cor |=>
      o_carry_in == $past(i_carry_in))
      else $error("carry pass wrong");
   chk_snap_middle: assert property (s_snap_cmd |=>
      o_flag_snapshot[6:1] == {$past(i_arith_overflow), $past(nz_now), $past(i_mid_carry),
      $past(i_peer_flag_three), $past(i_own_flag_one), $past(i_alu_zero)})
      else $error("snapshot order wrong");
   chk_snap_hold: assert property (!is_snap |=> $stable(o_flag_snapshot))
      else $error("snapshot moved");

   // ----------------------------------------
   // test and branch checks
   // ----------------------------------------
   sequence s_exit_cmd;
      pcp_mode;
   endsequence

   chk_repeat_exit: assert property (s_exit_cmd |=>
      o_repeat_exit == ($past(main_test) == $past(polarity)))
      else $error("repeat exit wrong");
   chk_alt_select: assert property (branch_mode && test_type |=>
      o_branch_take == ($past(alt_test) == $past(polarity)))
      else $error("alternate test wrong");
   chk_take_refused: assert property (!branch_mode |=> !o_branch_take)
      else $error("branch outside mode 0");
   chk_branch_type: assert property (branch_mode |=> o_branch_type == $past(btype))
      else $error("branch type wrong");
   chk_override_hold: assert property (over_q && !use_over |=> o_continue_override)
      else $error("override lost");
   chk_override_only: assert property (!set_over && !over_q |=> !o_continue_override)
      else $error("override without cause");

   // ----------------------------------------
   // count enable checks
   // ----------------------------------------
   chk_enable_onehot: assert property ($onehot(ce_q))
      else $error("enable state broken");
   chk_enable_hold: assert property (!cnt_load && !is_tog |=>
      o_counter_enable == $past(ce_q == mtb_pkg::MTB_CE_RUNNING))
      else $error("enable moved");
   chk_restart_late: assert property (is_tog && !cnt_load && ce_q == mtb_pkg::MTB_CE_STOPPED
      |-> !ce_gate) else $error("restart early");
endmodule : mtb_control

/* bench/mtb_alu_model.sv */
// flag source standing in for the bit-slice datapath
// assumes the bench sets the flag pattern between clock edges
`timescale 1ns/1ps
module mtb_alu_model (
   input wire logic [8:0] i_pattern,
   output logic [8:0] o_flags
);
   // bits: carry, zero, own1, peer3, mid, ovf, msb, cin, cin delayed
   assign o_flags = i_pattern;
endmodule : mtb_alu_model

/* bench/mtb_control_tb.sv */
// self-checking bench for the test and branch control block
// assumes mtb_control on one 100 MHz clock, sync active-low reset
`timescale 1ns/1ps
module mtb_control_tb;
   logic clk, nrst, valid, asl, hld, ild;
   logic [1:0] mode;
   logic [7:0] field, alt, sel_fill;
   logic [15:0] mt;
   logic [2:0] asd;
   logic [8:0] pat, fl;
   logic fc, bt, rx, ci, up, nz, ce, ov;
   logic [1:0] ty;
   logic [7:0] lc, snap;
   int bad_count = 0;
   int n_tests = 0;
   mtb_alu_model ALU (.i_pattern(pat), .o_flags(fl));
   mtb_control DUT (.i_clock(clk), .i_nrst(nrst), .i_valid(valid), .i_mode(mode), .i_field(field),
      .i_main_tests(mt), .i_alt_tests(alt), .i_alt_sel_load(asl), .i_alt_sel_data(asd),
      .i_carry_in(fl[7]), .i_carry_delayed(fl[8]), .i_carry_out(fl[0]), .i_alu_zero(fl[1]),
      .i_own_flag_one(fl[2]), .i_peer_flag_three(fl[3]), .i_mid_carry(fl[4]),
      .i_arith_overflow(fl[5]), .i_result_msb(fl[6]), .i_host_counter_load(hld),
      .i_inner_counter_load(ild), .o_force_continue(fc), .o_branch_take(bt), .o_branch_type(ty),
      .o_repeat_exit(rx), .o_carry_in(ci), .o_loop_count(lc), .o_loop_count_up(up),
      .o_loop_count_nonzero(nz), .o_flag_snapshot(snap), .o_counter_enable(ce),
      .o_continue_override(ov));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic op(input logic [1:0] m, input logic [7:0] f);
      @(posedge clk); #1; valid = 1'b1; mode = m; field = f;
      @(posedge clk); #1; valid = 1'b0; mode = 2'h3;
   endtask : op
   task automatic pulse(input int k);
      @(posedge clk); #1; hld = (k == 0); ild = (k == 1); asl = (k == 2);
      @(posedge clk); #1; hld = 1'b0; ild = 1'b0; asl = 1'b0;
   endtask : pulse
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   initial begin
      #20000;
      bad_count++;
      end_of_test();
   end
   initial begin
      nrst = 1'b0; valid = 1'b0; mode = 2'h3; field = 8'h00; mt = 16'h0000; alt = 8'h00;
      asl = 1'b0; asd = 3'h3; hld = 1'b0; ild = 1'b0; pat = 9'h000;
      repeat (2) @(posedge clk);
      #1; nrst = 1'b1;
      chk({ov, ce}, 8'h00);
      $display("reset test done");
      op(1, 8'h20); chk(lc, 8'h00);
      op(1, 8'h60); chk({nz, lc}, 16'h01ff);
      op(1, 8'h40); op(1, 8'h40); chk({up, lc}, 16'h0101);
      op(1, 8'h20);
      chk({nz, up, lc}, 16'h0300);
      op(1, 8'h40);
      chk({up, lc}, 16'h0101);
      pat = 9'h155;
      op(1, 8'h80); chk(snap, {pat[6], pat[5], 1'b1, pat[4:0]});
      pat = 9'h0aa;
      op(1, 8'hc0); op(1, 8'he0); op(0, 8'h80); chk(snap, 8'hb5);
      chk(lc, 8'h01);
      pat = 9'h100;
      op(1, 8'h00); chk(ci, 8'h01);
      $display("control point test done");
      pulse(0); chk(ce, 8'h01);
      op(1, 8'ha0); chk(ce, 8'h00);
      op(1, 8'ha0); chk(ce, 8'h01);
      op(0, 8'ha0); chk(ce, 8'h01);
      op(1, 8'ha0); pulse(1); chk(ce, 8'h01);
      $display("count enable test done");
      for (int p = 0; p < 2; p++) begin
         for (int t = 0; t < 2; t++) begin
            mt = 16'h0000;
            mt[5] = t[0];
            op(0, {3'h2, p[0], 4'h5}); chk({fc, bt, ty}, {6'h0, 1'b1, t[0] == p[0], 2'h1});
            op(1, {3'h7, p[0], 4'h5}); chk({bt, rx}, {7'h0, t[0] == p[0]});
         end
      end
      mt = 16'h0000; alt = 8'h08; asd = 3'h3;
      pulse(2);
      op(0, 8'h70); chk({bt, ty}, 8'h05);
      $display("branch test done");
      mt = 16'h0020;
      op(0, 8'hd5); chk(ov, 8'h01);
      op(2, 8'h00); chk({fc, ov}, 8'h02);
      $display("override test done");
      end_of_test();
   end
endmodule : mtb_control_tb
